// >>> hdl/dpd_cke_ctrl.sv
// DDR2 power-down and self refresh decoder driven by CKE and the command.
// Function
// - CKE high-to-low with NOP or DESELECT enters power-down.
// - All banks idle gives precharge power-down; an open row gives active.
// - Power-down disables input and output buffers except clock, ODT, CKE.
// - DLL is frozen during precharge power-down.
// - CKE low-to-high with NOP or DESELECT exits power-down.
// - CKE high-to-low with REFRESH enters self refresh, banks idle only.
// - Undefined CKE and command combinations are illegal.
// - No on-die termination during self refresh.
`timescale 1ns/1ps
`default_nettype none

module dpd_cke_ctrl #(
  parameter int BANKS = dpd_pkg::DPD_BANKS
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic mem_ck_in,
  input wire logic cke_in,
  input wire dpd_pkg::dpd_cmd_t cmd_in,
  input wire logic odt_in,
  input wire logic [BANKS-1:0] bank_open_in,
  output logic buffers_off_out,
  output logic dll_frozen_out,
  output logic odt_active_out,
  output logic self_refresh_out,
  output logic illegal_out
);

  // Elaboration check: the open-bank vector needs at least one bank, and the
  // decode is not meant for more than sixteen.
  if (BANKS < 1 || BANKS > 16) begin : g_bad_banks
    $error("BANKS out of range");
  end

  // Link-domain reset: the core reset is brought over by two flops.
  // The link clock must run while reset is held, or the link logic keeps its
  // old state; the controller keeps CK running at all times, so this is cheap.
  logic [1:0] lrst_sync_r;
  logic [1:0] lrst_sync_nxt;
  logic lrst_n;
  always_comb begin
    lrst_sync_nxt = {lrst_sync_r[0], rst_n_in};
  end
  always_ff @(posedge mem_ck_in) begin
    lrst_sync_r <= lrst_sync_nxt;
  end
  assign lrst_n = lrst_sync_r[1];

  // Link-side state, clocked by the memory clock itself.
  dpd_pkg::dpd_state_t state_r;
  dpd_pkg::dpd_state_t state_nxt;
  logic cke_prev_r;
  logic cke_prev_nxt;
  logic ill_r;
  logic ill_nxt;
  // ODT is registered with the state so that both change on the same link edge; it leaves gated by the self refresh decode.
  logic odt_smp_r;
  logic odt_smp_nxt;
  logic is_nop;
  logic any_open;

  // DESELECT is any command with chip select high; the other pins then do not count.
  assign is_nop = cmd_in.cs_n || ({1'b0, cmd_in.ras_n, cmd_in.cas_n, cmd_in.we_n}
                  == dpd_pkg::DPD_CMD_NOP);
  // Any open row makes a power-down active rather than precharge.
  assign any_open = |bank_open_in;

  // CKE truth table decode; previous CKE versus the current edge.
  // Only the table itself is policed: minimum CKE pulse widths and exit waits
  // belong to the controller, and a breach of them is not reported here.
  always_comb begin
    state_nxt = state_r;
    cke_prev_nxt = cke_in;
    odt_smp_nxt = odt_in;
    ill_nxt = 1'b0;
    unique case (state_r)
      dpd_pkg::DPD_NORMAL: begin
        if (cke_prev_r && !cke_in) begin
          if (is_nop) begin
            state_nxt = any_open ? dpd_pkg::DPD_ACT_PD : dpd_pkg::DPD_PRE_PD;
          end else if ({1'b0, cmd_in.ras_n, cmd_in.cas_n, cmd_in.we_n}
                       == dpd_pkg::DPD_CMD_REFRESH && !any_open) begin
            state_nxt = dpd_pkg::DPD_SELF_REF;
          end else begin
            ill_nxt = 1'b1;
          end
        end else if (!cke_prev_r && cke_in) begin
          ill_nxt = !is_nop;
        end
      end
      dpd_pkg::DPD_PRE_PD, dpd_pkg::DPD_ACT_PD, dpd_pkg::DPD_SELF_REF: begin
        // A refused exit keeps the state; the next NOP with CKE high still leaves.
        if (cke_in) begin
          if (is_nop) begin
            state_nxt = dpd_pkg::DPD_NORMAL;
          end else begin
            ill_nxt = 1'b1;
          end
        end
      end
      default: begin
        // Unused state codes fall back to normal operation and are reported.
        state_nxt = dpd_pkg::DPD_NORMAL;
        ill_nxt = 1'b1;
      end
    endcase
  end

  // Registering stage for the link-side decoder.
  always_ff @(posedge mem_ck_in) begin
    if (!lrst_n) begin
      state_r <= dpd_pkg::DPD_NORMAL;
      cke_prev_r <= dpd_pkg::DPD_CKE_RESET;
      odt_smp_r <= 1'b0;
      ill_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cke_prev_r <= cke_prev_nxt;
      odt_smp_r <= odt_smp_nxt;
      ill_r <= ill_nxt;
    end
  end

  // Level status bits leaving the link domain; the illegal pulse becomes a toggle.
  // A one-cycle pulse could fall between two core edges if the clocks were close;
  // a toggle is seen at any ratio, provided illegal events are a few core cycles apart.
  logic buf_lvl;
  logic dll_lvl;
  logic sr_lvl;
  logic odt_lvl;
  logic ill_tog_r;
  logic ill_tog_nxt;
  assign buf_lvl = (state_r != dpd_pkg::DPD_NORMAL);
  assign dll_lvl = (state_r == dpd_pkg::DPD_PRE_PD);
  // Self refresh is reported on its own so the core can time its exit wait.
  assign sr_lvl = (state_r == dpd_pkg::DPD_SELF_REF);
  assign odt_lvl = odt_smp_r && !sr_lvl;
  always_comb begin
    ill_tog_nxt = ill_tog_r ^ ill_r;
  end
  always_ff @(posedge mem_ck_in) begin
    if (!lrst_n) begin
      ill_tog_r <= 1'b0;
    end else begin
      ill_tog_r <= ill_tog_nxt;
    end
  end

  // Two-flop crossing into the core clock; the first stage feeds only the second.
  // Each bit is a level that changes at most once per link cycle, far slower than the crossing.
  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic ill_seen_r;
  logic [4:0] s1_nxt;
  logic [4:0] s2_nxt;
  logic ill_seen_nxt;
  logic buf_nxt;
  logic dll_nxt;
  logic odt_nxt;
  logic sr_nxt;
  logic illo_nxt;
  always_comb begin
    s1_nxt = {ill_tog_r, odt_lvl, sr_lvl, dll_lvl, buf_lvl};
    s2_nxt = s1_r;
    ill_seen_nxt = s2_r[4];
    buf_nxt = s2_r[0];
    dll_nxt = s2_r[1];
    sr_nxt = s2_r[2];
    odt_nxt = s2_r[3];
    illo_nxt = s2_r[4] ^ ill_seen_r;
  end
  // Status outputs come straight from core-domain flops.
  // The core reset clears them at the next core edge; the link reset follows two link edges later.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s1_r <= 5'h00;
      s2_r <= 5'h00;
      ill_seen_r <= 1'b0;
      buffers_off_out <= 1'b0;
      dll_frozen_out <= 1'b0;
      self_refresh_out <= 1'b0;
      odt_active_out <= 1'b0;
      illegal_out <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      ill_seen_r <= ill_seen_nxt;
      buffers_off_out <= buf_nxt;
      dll_frozen_out <= dll_nxt;
      self_refresh_out <= sr_nxt;
      odt_active_out <= odt_nxt;
      illegal_out <= illo_nxt;
    end
  end

endmodule : dpd_cke_ctrl
`default_nettype wire

// >>> hdl/dpd_pkg.sv
// Package for the DDR2 power-down and CKE state decoder.
package dpd_pkg;

  // Command encoding as seen on the chip-select, RAS, CAS and WE pins.
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } dpd_cmd_t;

  // Power state of the memory.
  typedef enum logic [2:0] {
    DPD_NORMAL,
    DPD_PRE_PD,
    DPD_ACT_PD,
    DPD_SELF_REF
  } dpd_state_t;

  // Status reported toward the core clock domain.
  typedef struct packed {
    logic buffers_off;
    logic dll_frozen;
    logic odt_blocked;
    logic illegal;
  } dpd_status_t;

  localparam logic [3:0] DPD_CMD_NOP = 4'h7;
  localparam logic [3:0] DPD_CMD_REFRESH = 4'h1;
  localparam logic [3:0] DPD_CMD_ACTIVATE = 4'h3;
  localparam logic [3:0] DPD_CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] DPD_CMD_LOAD_MODE = 4'h0;
  localparam logic DPD_CKE_RESET = 1'h0;
  localparam int DPD_BANKS = 8;
  localparam logic [2:0] DPD_SYNC_RESET = 3'h0;

endpackage : dpd_pkg

// >>> tb/dpd_cke_ctrl_monitor.sv
// Checker for the power state outputs of the CKE decoder.
`timescale 1ns/1ps
`default_nettype none
module dpd_cke_ctrl_monitor (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic buffers_off_out,
  input wire logic dll_frozen_out,
  input wire logic odt_active_out,
  input wire logic self_refresh_out,
  input wire logic illegal_out
);
  // All outputs are registered in the core domain, so one clock serves every check.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_dll; dll_frozen_out |-> buffers_off_out; endproperty
  a_dll: assert property (p_dll) else $error("dll frozen with buffers on");
  property p_kind; dll_frozen_out |-> !self_refresh_out; endproperty
  a_kind: assert property (p_kind) else $error("dll frozen in self refresh");
  property p_srbuf; self_refresh_out |-> buffers_off_out; endproperty
  a_srbuf: assert property (p_srbuf) else $error("self refresh with buffers on");
  property p_odt; self_refresh_out |-> !odt_active_out; endproperty
  a_odt: assert property (p_odt) else $error("termination in self refresh");
  property p_ill; illegal_out |=> !illegal_out; endproperty
  a_ill: assert property (p_ill) else $error("illegal pulse too long");
  property p_pd; $rose(buffers_off_out) |-> buffers_off_out [*8]; endproperty
  a_pd: assert property (p_pd) else $error("power-down not held");
  property p_exit; $fell(buffers_off_out) |-> !buffers_off_out [*8]; endproperty
  a_exit: assert property (p_exit) else $error("exit not held");
  property p_sr; $rose(self_refresh_out) |-> self_refresh_out [*8]; endproperty
  a_sr: assert property (p_sr) else $error("self refresh not held");
  c_pre: cover property (dll_frozen_out);
  c_act: cover property (buffers_off_out && !dll_frozen_out && !self_refresh_out);
  c_sr: cover property (self_refresh_out);
  c_ill: cover property (illegal_out);
endmodule // dpd_cke_ctrl_monitor
bind dpd_cke_ctrl dpd_cke_ctrl_monitor i_mon (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .buffers_off_out(buffers_off_out), .dll_frozen_out(dll_frozen_out),
  .odt_active_out(odt_active_out), .self_refresh_out(self_refresh_out),
  .illegal_out(illegal_out));
`default_nettype wire

// >>> tb/dpd_ctrl_model.sv
// Memory controller model that makes CK and drives CKE, command and ODT.
`timescale 1ns/1ps
`default_nettype none
module dpd_ctrl_model (
  output logic mem_ck_out,
  output logic cke_out,
  output dpd_pkg::dpd_cmd_t cmd_out,
  output logic odt_out,
  output logic [7:0] bank_open_out
);
  // one fixed CK period, so every exit is at the entry frequency.
  initial begin
    mem_ck_out = 1'b0;
    cke_out = 1'b0;
    cmd_out = 4'h7;
    odt_out = 1'b0;
    bank_open_out = 8'h00;
    #3.1;
    forever #32 mem_ck_out = ~mem_ck_out;
  end
  // level held four edges; the command only rides the first.
  // no READ or WRITE is ever issued, so no burst is open.
  // each power-down lasts four link clocks only.
  // banks are set directly, no row command precedes entry.
  task automatic drive(input logic c, input logic [3:0] k, input logic [7:0] b, input logic o);
    @(negedge mem_ck_out);
    cke_out = c;
    cmd_out = k;
    bank_open_out = b;
    odt_out = o;
    @(negedge mem_ck_out);
    cmd_out = 4'h7;
    repeat (2) @(negedge mem_ck_out);
  endtask
endmodule // dpd_ctrl_model
`default_nettype wire

// >>> tb/test_dpd_cke_ctrl.sv
// Self-checking bench for the CKE power state decoder.
`timescale 1ns/1ps
`default_nettype none
module test_dpd_cke_ctrl;
  logic clk_in, rst_n_in, mem_ck, cke, odt, bo, df, oa, sr, il, ex_il, pcke, ill_seen;
  dpd_pkg::dpd_cmd_t cmd;
  logic [7:0] banks, b;
  logic [3:0] k;
  logic [31:0] rnd = 32'h98B8;
  logic [3:0] tbl [6] = '{4'h7, 4'hF, 4'h1, 4'h3, 4'h2, 4'h0};
  int n_mismatch = 0;
  int cmp_count = 0;
  int st = 0;
  dpd_ctrl_model i_dpd_ctrl_model (.mem_ck_out(mem_ck), .cke_out(cke), .cmd_out(cmd),
    .odt_out(odt), .bank_open_out(banks));
  dpd_cke_ctrl i_dpd_cke_ctrl (.clk_in(clk_in), .rst_n_in(rst_n_in), .mem_ck_in(mem_ck),
    .cke_in(cke), .cmd_in(cmd), .odt_in(odt), .bank_open_in(banks), .buffers_off_out(bo),
    .dll_frozen_out(df), .odt_active_out(oa), .self_refresh_out(sr), .illegal_out(il));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [4:0] e, input logic [4:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error outputs expected %b seen %b", e, g);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Core clock; the illegal pulse is one cycle wide so it is latched here.
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) if (il === 1'b1) ill_seen = 1'b1;
  // Watchdog sized well above the sixty steps of the main run.
  initial begin
    #40000;
    n_mismatch++;
    finish_test();
  end
  // Reset spans enough link edges to reach the link logic, then random steps.
  initial begin
    pcke = 1'b0;
    rst_n_in = 1'b0;
    repeat (5) @(posedge mem_ck);
    @(negedge clk_in);
    rst_n_in = 1'b1;
    ill_seen = 1'b0;
    // The link reset leaves two link edges later; no request before it has gone.
    repeat (3) @(posedge mem_ck);
    chk(5'h00, {bo, df, oa, sr, ill_seen});
    repeat (60) begin
      rnd = lfsr(rnd);
      k = tbl[rnd[2:0] % 6];
      b = rnd[4] ? rnd[15:8] : 8'h00;
      ex_il = !pcke && !(k[3] || k == 4'h7);
      if (!pcke) st = 0;
      else if (st == 0 && (k[3] || k == 4'h7)) st = (b != 0) ? 2 : 1;
      else if (k == 4'h1 && b == 0) st = 3;
      else ex_il = 1'b1;
      ill_seen = 1'b0;
      i_dpd_ctrl_model.drive(!pcke, k, b, rnd[5]);
      pcke = !pcke;
      chk({st != 0, st == 1, rnd[5] && st != 3, st == 3, ex_il}, {bo, df, oa, sr, ill_seen});
    end
    finish_test();
  end
endmodule // test_dpd_cke_ctrl
`default_nettype wire
